// [bench/rx_bit_error_tester_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin error_cnt++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module rx_bit_error_tester_tb_top;
  import bit_error_tester_pkg::*;
  // ************************************************************
  // signals
  // ************************************************************
  logic i_core_clk = 1'b0; // 40 MHz core clock
  logic i_rstn = 1'b0; // held low at start
  reg_req_t req = '0; // register request
  logic send = 1'b0; // stream on
  logic flip = 1'b0; // corrupt this bit
  logic [1:0] mode = 2'd0; // word, zeros or ones
  rx_bit_t rx; // stream into the block
  logic [15:0] rdata; // read data
  logic irq; // interrupt line
  logic locked; // live lock
  int error_cnt = 0; // mismatches
  int n_compared = 0; // comparisons
  logic [31:0] nbits = 32'h0; // bits sent since reset
  logic [31:0] bits_snap; // bit count snapshot
  logic [23:0] err_snap; // error count snapshot
  logic [23:0] err_base; // earlier error snapshot
  rx_bit_error_tester u_dut (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_rx(rx), .i_req(req), .o_rdata(rdata),
    .o_irq(irq), .o_locked(locked));
  rx_stream_model u_far (.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_send(send), .i_mode(mode), .i_flip(flip),
    .o_rx(rx));
  // ************************************************************
  // tasks
  // ************************************************************
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // one-cycle write strobe
  task automatic reg_wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    req <= {1'b1, 1'b0, a, d};
    @(posedge i_core_clk);
    req <= '0;
  endtask : reg_wr
  // one-cycle read strobe, data taken in the following cycle only
  task automatic reg_rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge i_core_clk);
    req <= {1'b0, 1'b1, a, 16'h0000};
    @(posedge i_core_clk);
    req <= '0;
    #1 d = rdata;
  endtask : reg_rd
  // n bits, flipping fn of them from index f0
  task automatic send_bits(input int n, input logic [1:0] m, input int f0, input int fn);
    for (int i = 0; i < n; i++) begin
      @(posedge i_core_clk);
      send <= 1'b1;
      mode <= m;
      flip <= (i >= f0) && (i < f0 + fn);
      nbits = nbits + 32'h1;
    end
    @(posedge i_core_clk);
    send <= 1'b0;
    flip <= 1'b0;
    mode <= 2'd0;
    // let the last bit settle before anyone looks at lock or interrupt
    #1;
  endtask : send_bits
  // load bit 0 then 1 snapshots, then 0 rearms; flags register read clears flags
  task automatic snap(input logic [15:0] en);
    logic [15:0] lo;
    logic [15:0] hi;
    logic [15:0] el;
    logic [15:0] eh;
    reg_wr(ADDR_TESTER_CONTROL, en | 16'h0001);
    reg_wr(ADDR_TESTER_CONTROL, en);
    reg_rd(ADDR_BIT_COUNT_LOW, lo);
    reg_rd(ADDR_BIT_COUNT_HIGH, hi);
    reg_rd(ADDR_ERR_LOW_FLAGS, el);
    reg_rd(ADDR_ERR_HIGH, eh);
    bits_snap = {hi, lo};
    err_snap = {eh, el[15:8]};
  endtask : snap
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  // ************************************************************
  // sequence
  // ************************************************************
  initial begin
    repeat (100000) @(posedge i_core_clk);
    error_cnt++;
    $display("MISMATCH t=%0t run did not finish", $time);
    final_report();
  end
  initial begin
    logic [15:0] rd;
    logic [11:0] amap [6];
    amap = '{ADDR_TESTER_CONTROL, ADDR_BIT_COUNT_LOW, ADDR_BIT_COUNT_HIGH, ADDR_ERR_LOW_FLAGS,
      ADDR_ERR_HIGH, ADDR_IRQ_STATUS};
    repeat (10) @(posedge i_core_clk);
    i_rstn <= 1'b1;
    foreach (amap[k]) begin
      reg_rd(amap[k], rd);
      `CHK(rd, 16'h0000)
    end
    reg_rd(12'h5fc, rd);
    `CHK(rd, 16'h0000)
    reg_wr(ADDR_ERR_HIGH, 16'hffff);
    reg_rd(ADDR_ERR_HIGH, rd);
    `CHK(rd, 16'h0000)
    // lock up on clean word
    send_bits(80, 2'd0, 0, 0);
    `CHK(locked, 1'b1)
    reg_rd(ADDR_ERR_LOW_FLAGS, rd);
    `CHK(rd[6:0], 7'h01)
    reg_rd(ADDR_IRQ_STATUS, rd);
    `CHK(rd, 16'h0004)
    snap(16'h0000);
    `CHK(bits_snap, nbits)
    err_base = err_snap;
    // two spaced errors while locked, error cause enabled
    reg_wr(ADDR_TESTER_CONTROL, 16'h4000);
    send_bits(40, 2'd0, 10, 1);
    send_bits(60, 2'd0, 10, 1);
    `CHK(irq, 1'b1)
    reg_rd(ADDR_ERR_LOW_FLAGS, rd);
    `CHK(rd[ST_BIT_ERR], 1'b1)
    reg_rd(ADDR_ERR_LOW_FLAGS, rd);
    `CHK(rd[ST_BIT_ERR], 1'b0)
    reg_rd(ADDR_IRQ_STATUS, rd);
    `CHK(rd, 16'h0002)
    `CHK(irq, 1'b0)
    snap(16'h4000);
    `CHK(bits_snap, nbits)
    `CHK(err_snap, err_base + 24'd2)
    err_base = err_snap;
    // error burst drops lock with every cause masked, then relock
    reg_wr(ADDR_TESTER_CONTROL, 16'h0000);
    send_bits(60, 2'd0, 20, 12);
    `CHK(locked, 1'b0)
    `CHK(irq, 1'b0)
    send_bits(80, 2'd0, 0, 0);
    `CHK(locked, 1'b1)
    reg_rd(ADDR_ERR_LOW_FLAGS, rd);
    `CHK(rd[ST_LOCK_LOST], 1'b1)
    reg_rd(ADDR_IRQ_STATUS, rd);
    `CHK(rd, 16'h0006)
    snap(16'h0000);
    `CHK(bits_snap, nbits)
    `CHK(err_snap >= err_base + 24'd6, 1'b1)
    // long zeros then long ones; flag read clears only after an opposite bit
    for (int v = 1; v < 3; v++) begin
      send_bits(40, v[1:0], 0, 0);
      reg_rd(ADDR_ERR_LOW_FLAGS, rd);
      `CHK(rd[ST_ALL_ZEROS + v - 1], 1'b1)
      reg_rd(ADDR_ERR_LOW_FLAGS, rd);
      `CHK(rd[ST_ALL_ZEROS + v - 1], 1'b1)
      send_bits(4, 2'd0, 0, 0);
      reg_rd(ADDR_ERR_LOW_FLAGS, rd);
      `CHK(rd[ST_ALL_ZEROS + v - 1], 1'b1)
      reg_rd(ADDR_ERR_LOW_FLAGS, rd);
      `CHK(rd[ST_ALL_ZEROS + v - 1], 1'b0)
    end
    final_report();
  end
endmodule : rx_bit_error_tester_tb_top
`default_nettype wire

// [bench/rx_stream_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// far-end stream source, period-32 word sent lsb first
// ************************************************************
module rx_stream_model
  import bit_error_tester_pkg::*;
#(
  parameter logic [31:0] PATTERN = 32'h5ad6b5ad // runs of equal bits never pass two
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // control from the bench
  input wire logic i_send,
  input wire logic [1:0] i_mode,
  input wire logic i_flip,
  // stream out
  output var bit_error_tester_pkg::rx_bit_t o_rx
);
  logic [4:0] idx_reg; // position in the word
  logic last_reg; // last bit put on the line
  logic bit_now; // bit of this cycle
  // word bit, forced zeros, forced ones; flip only in word mode
  always_comb begin
    case (i_mode)
      2'd1: bit_now = 1'b0;
      2'd2: bit_now = 1'b1;
      default: bit_now = PATTERN[idx_reg] ^ i_flip;
    endcase
  end
  // idle line shows the inverse of the last bit, so stale data never looks fresh
  assign o_rx = {i_send, i_send ? bit_now : ~last_reg};
  // word position advances on every bit, so the pattern stays aligned
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      idx_reg <= 5'h00;
      last_reg <= 1'b0;
    end else if (i_send) begin
      idx_reg <= idx_reg + 5'h01;
      last_reg <= bit_now;
    end
  end
endmodule : rx_stream_model
`default_nettype wire

// [verilog/bit_error_tester_pkg.sv]
`default_nettype none
package bit_error_tester_pkg;
  // ************************************************************
  // register map, byte addresses on a 12-bit address
  // ************************************************************
  localparam logic [11:0] ADDR_TESTER_CONTROL = 12'h500; // control and interrupt enables
  localparam logic [11:0] ADDR_BIT_COUNT_LOW = 12'h510; // snapshot of bit counter, low half
  localparam logic [11:0] ADDR_BIT_COUNT_HIGH = 12'h514; // snapshot of bit counter, high half
  localparam logic [11:0] ADDR_ERR_LOW_FLAGS = 12'h518; // flags plus error count low byte
  localparam logic [11:0] ADDR_ERR_HIGH = 12'h51c; // error count upper sixteen bits
  localparam logic [11:0] ADDR_IRQ_STATUS = 12'h520; // sticky interrupt causes
  // ************************************************************
  // field positions
  // ************************************************************
  localparam int CTL_LOAD_COUNTERS = 0; // rising edge snapshots the counters
  localparam int CTL_OVF_IRQ_EN = 13; // overflow cause enable
  localparam int CTL_ERR_IRQ_EN = 14; // bit error cause enable
  localparam int CTL_LOCK_IRQ_EN = 15; // lock change cause enable
  localparam int ST_LOCKED = 0; // real-time lock status
  localparam int ST_ERR_OVF = 1; // error counter overflow
  localparam int ST_BIT_OVF = 2; // bit counter overflow
  localparam int ST_BIT_ERR = 3; // bit error seen
  localparam int ST_LOCK_LOST = 4; // lock lost
  localparam int ST_ALL_ZEROS = 5; // all zeros seen
  localparam int ST_ALL_ONES = 6; // all ones seen
  localparam int IRQ_OVF = 0; // interrupt status: overflow
  localparam int IRQ_ERR = 1; // interrupt status: bit error
  localparam int IRQ_LOCK = 2; // interrupt status: lock change
  // ************************************************************
  // widths, reset values and counts
  // ************************************************************
  localparam int BIT_CNT_W = 32; // bit counter width
  localparam int ERR_CNT_W = 24; // error counter width
  localparam int REG_W = 16; // register data width
  localparam logic [15:0] REG_RESET = 16'h0000; // every register resets to zero
  localparam int LOCK_MATCH_COUNT = 32; // consecutive matches to lock
  localparam int LOSS_ERR_COUNT = 6; // errors in window that drop lock
  localparam int LOSS_WINDOW_BITS = 64; // loss window length in bits
  localparam int RUN_LENGTH = 31; // equal bits for all-zeros / all-ones
  localparam int PATTERN_W = 32; // longest repetitive pattern
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [0:0] {HUNT = 1'b0, LOCKED = 1'b1} lock_state_t; // gray along hunt-lock
  typedef struct packed {
    logic wr; // write strobe
    logic rd; // read strobe
    logic [11:0] addr; // byte address
    logic [15:0] wdata; // write data
  } reg_req_t;
  typedef struct packed {
    logic valid; // one-cycle bit strobe
    logic data; // received bit value
  } rx_bit_t;
endpackage : bit_error_tester_pkg
`default_nettype wire

// [verilog/run_detect.sv]
`timescale 1ns/10ps
`default_nettype none
// counts consecutive bits equal to a target value
module run_detect #(
  parameter logic TARGET = 1'b0,
  parameter int LEN = 31
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // bit stream
  input wire logic i_valid,
  input wire logic i_bit,
  // results
  output logic o_hit,
  output logic o_broken
);
  logic [5:0] run_reg; // current run length, saturates at LEN
  // ************************************************************
  // run counter
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      run_reg <= '0;
    end else if (i_valid) begin
      if (i_bit != TARGET) begin
        run_reg <= '0;
      end else if (run_reg != 6'(LEN)) begin
        run_reg <= run_reg + 6'h01;
      end
    end
  end
  // hit while the run stands at its length, broken on the opposite bit
  assign o_hit = i_valid && (i_bit == TARGET) && (run_reg >= 6'(LEN - 1));
  assign o_broken = i_valid && (i_bit != TARGET);
endmodule : run_detect
`default_nettype wire

// [verilog/rx_bit_error_tester.sv]
// Design decision made here: strobed register access.
`timescale 1ns/10ps
`default_nettype none
// How it works
// RL1 - bit counter counts every received bit
// RL2 - error counter counts every mismatched bit
// RL3 - counters run on while out of lock
// RL4 - load bit rising edge snapshots counters
// RL5 - counters saturate, set their overflow flags
// RL6 - error overflow flag, clear on read
// RL7 - bit overflow flag, clear on read
// RL8 - lock after 32 consecutive matching bits
// RL9 - drop lock on 6 errors in 64
// RL10 - bit error flag only while locked
// RL11 - lock lost flag set entering hunt
// RL12 - all zeros after 31, clear needs one
// RL13 - all ones after 31, clear needs zero
// RL14 - flag register layout with error low byte
// RL15 - upper error count register
// RL16 - upper bit count register readable
// RL17 - counter and status registers reset zero
// RL18 - interrupt causes gated by enable bits
// RL19 - locked compare against regenerated pattern
module rx_bit_error_tester (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // received stream
  input wire bit_error_tester_pkg::rx_bit_t i_rx,
  // register port
  input wire bit_error_tester_pkg::reg_req_t i_req,
  output logic [15:0] o_rdata,
  // interrupt
  output logic o_irq,
  // live status
  output logic o_locked
);
  import bit_error_tester_pkg::*;

  // ************************************************************
  // declarations
  // ************************************************************
  lock_state_t state_reg; // hunt or locked
  logic [PATTERN_W-1:0] hist_reg; // last 32 received bits
  logic [PATTERN_W-1:0] ring_reg; // regenerated pattern while locked
  logic [5:0] match_reg; // consecutive matches in hunt
  logic [5:0] win_reg; // position inside the loss window
  logic [2:0] win_err_reg; // errors inside the loss window
  logic [15:0] ctrl_reg; // control register
  logic [BIT_CNT_W-1:0] bit_snap_reg; // host view of bit counter
  logic [ERR_CNT_W-1:0] err_snap_reg; // host view of error counter
  logic [6:1] flag_reg; // latched flags, bits 1..6
  logic [2:0] irq_stat_reg; // sticky interrupt causes
  logic [15:0] rdata_reg; // read data, valid one cycle after strobe
  logic zero_broken_reg; // a one arrived since all-zeros set
  logic one_broken_reg; // a zero arrived since all-ones set
  logic [BIT_CNT_W-1:0] bit_count; // live bit counter
  logic [ERR_CNT_W-1:0] err_count; // live error counter
  logic bit_full_hit; // bit counter reached all ones
  logic err_full_hit; // error counter reached all ones
  logic zeros_hit; // 31 zeros seen
  logic ones_hit; // 31 ones seen
  logic zeros_broken; // a one seen
  logic ones_broken; // a zero seen
  logic expected; // bit the pattern predicts
  logic mismatch; // received bit differs from prediction
  logic lock_gain; // hunt to locked this cycle
  logic lock_drop; // locked to hunt this cycle
  logic rd_flags; // read of the flag register
  logic load_edge; // rising edge of the load bit
  logic [15:0] wr_ctrl; // incoming control word
  logic [15:0] rdata_next; // read mux output

  // ************************************************************
  // pattern compare
  // ************************************************************
  // in hunt the stream is its own reference, 32 bits back
  // RL19 regenerated copy when locked
  assign expected = (state_reg == LOCKED) ? ring_reg[PATTERN_W-1] : hist_reg[PATTERN_W-1];
  assign mismatch = i_rx.valid && (i_rx.data != expected);
  // RL8 lock on 32 matches
  assign lock_gain = (state_reg == HUNT) && i_rx.valid && !mismatch &&
                     (match_reg == 6'(LOCK_MATCH_COUNT - 1));
  // RL9 six errors in window
  assign lock_drop = (state_reg == LOCKED) && mismatch &&
                     (win_err_reg == 3'(LOSS_ERR_COUNT - 1));

  // history shift register, always running
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      hist_reg <= '0;
    end else if (i_rx.valid) begin
      hist_reg <= {hist_reg[PATTERN_W-2:0], i_rx.data};
    end
  end

  // regenerated pattern: captured at lock, then only rotated
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ring_reg <= '0;
    end else if (lock_gain) begin
      ring_reg <= {hist_reg[PATTERN_W-2:0], i_rx.data};
    end else if (i_rx.valid) begin
      ring_reg <= {ring_reg[PATTERN_W-2:0], ring_reg[PATTERN_W-1]};
    end
  end

  // ************************************************************
  // lock state machine
  // ************************************************************
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_reg <= HUNT;
    end else begin
      case (state_reg)
        // hunting for 32 matching positions
        HUNT: begin
          if (lock_gain) begin
            state_reg <= LOCKED;
          end
        end
        // locked until the window error limit
        LOCKED: begin
          if (lock_drop) begin
            state_reg <= HUNT;
          end
        end
        default: begin
          state_reg <= HUNT;
        end
      endcase
    end
  end

  // consecutive match counter, cleared by any mismatch in hunt
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      match_reg <= '0;
    end else if (state_reg == LOCKED) begin
      match_reg <= '0;
    end else if (i_rx.valid) begin
      match_reg <= mismatch ? 6'h00 : match_reg + 6'h01;
    end
  end

  // loss window: 64 bits, error tally restarts each window
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      win_reg <= '0;
      win_err_reg <= '0;
    end else if (state_reg != LOCKED) begin
      win_reg <= '0;
      win_err_reg <= '0;
    end else if (i_rx.valid) begin
      win_reg <= win_reg + 6'h01;
      if (win_reg == 6'(LOSS_WINDOW_BITS - 1)) begin
        win_err_reg <= '0;
      end else if (mismatch) begin
        win_err_reg <= win_err_reg + 3'h1;
      end
    end
  end

  // ************************************************************
  // counters
  // ************************************************************
  // RL1 every bit counted
  // RL3 never gated by lock
  sat_counter #(.W(BIT_CNT_W)) u_bit_counter (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_inc(i_rx.valid),
    .o_count(bit_count),
    .o_full_hit(bit_full_hit)
  );

  // RL2 every mismatch counted
  sat_counter #(.W(ERR_CNT_W)) u_error_counter (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_inc(mismatch),
    .o_count(err_count),
    .o_full_hit(err_full_hit)
  );

  // run detectors for stuck lines
  run_detect #(.TARGET(1'b0), .LEN(RUN_LENGTH)) u_zero_run (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_valid(i_rx.valid),
    .i_bit(i_rx.data),
    .o_hit(zeros_hit),
    .o_broken(zeros_broken)
  );

  run_detect #(.TARGET(1'b1), .LEN(RUN_LENGTH)) u_one_run (
    .i_core_clk(i_core_clk),
    .i_rstn(i_rstn),
    .i_valid(i_rx.valid),
    .i_bit(i_rx.data),
    .o_hit(ones_hit),
    .o_broken(ones_broken)
  );

  // ************************************************************
  // control register and snapshot
  // ************************************************************
  assign wr_ctrl = i_req.wdata;
  assign load_edge = i_req.wr && (i_req.addr == ADDR_TESTER_CONTROL) &&
                     wr_ctrl[CTL_LOAD_COUNTERS] && !ctrl_reg[CTL_LOAD_COUNTERS];

  // plain read/write control word
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ctrl_reg <= REG_RESET;
    end else if (i_req.wr && (i_req.addr == ADDR_TESTER_CONTROL)) begin
      ctrl_reg <= wr_ctrl;
    end
  end

  // RL4 snapshot on 0 to 1
  // RL17 snapshots reset to zero
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      bit_snap_reg <= '0;
      err_snap_reg <= '0;
    end else if (load_edge) begin
      bit_snap_reg <= bit_count;
      err_snap_reg <= err_count;
    end
  end

  // ************************************************************
  // latched flags
  // ************************************************************
  assign rd_flags = i_req.rd && (i_req.addr == ADDR_ERR_LOW_FLAGS);

  // opposite-bit trackers gate the all-zeros / all-ones clears
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      zero_broken_reg <= 1'b0;
      one_broken_reg <= 1'b0;
    end else begin
      zero_broken_reg <= zeros_hit ? 1'b0 : (zero_broken_reg | zeros_broken);
      one_broken_reg <= ones_hit ? 1'b0 : (one_broken_reg | ones_broken);
    end
  end

  // set wins over the clear-on-read in the same cycle
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      flag_reg <= '0;
    end else begin
      // RL5 RL6 error overflow latch
      flag_reg[ST_ERR_OVF] <= err_full_hit | (flag_reg[ST_ERR_OVF] & !rd_flags);
      // RL5 RL7 bit overflow latch
      flag_reg[ST_BIT_OVF] <= bit_full_hit | (flag_reg[ST_BIT_OVF] & !rd_flags);
      // RL10 error only when locked
      flag_reg[ST_BIT_ERR] <= (mismatch && state_reg == LOCKED) | (flag_reg[ST_BIT_ERR] & !rd_flags);
      // RL11 set on entering hunt
      flag_reg[ST_LOCK_LOST] <= lock_drop | (flag_reg[ST_LOCK_LOST] & !rd_flags);
      // RL12 zeros clear needs one
      flag_reg[ST_ALL_ZEROS] <= zeros_hit |
                                (flag_reg[ST_ALL_ZEROS] & !(rd_flags & (zero_broken_reg | zeros_broken)));
      // RL13 ones clear needs zero
      flag_reg[ST_ALL_ONES] <= ones_hit |
                               (flag_reg[ST_ALL_ONES] & !(rd_flags & (one_broken_reg | ones_broken)));
    end
  end

  // ************************************************************
  // interrupts
  // ************************************************************
  // sticky causes, cleared by reading their register; set wins
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg[IRQ_OVF] <= bit_full_hit | err_full_hit |
                               (irq_stat_reg[IRQ_OVF] & !(i_req.rd && i_req.addr == ADDR_IRQ_STATUS));
      irq_stat_reg[IRQ_ERR] <= (mismatch && state_reg == LOCKED) |
                               (irq_stat_reg[IRQ_ERR] & !(i_req.rd && i_req.addr == ADDR_IRQ_STATUS));
      irq_stat_reg[IRQ_LOCK] <= lock_gain | lock_drop |
                                (irq_stat_reg[IRQ_LOCK] & !(i_req.rd && i_req.addr == ADDR_IRQ_STATUS));
    end
  end

  // RL18 enables gate each cause
  assign o_irq = (irq_stat_reg[IRQ_OVF] & ctrl_reg[CTL_OVF_IRQ_EN]) |
                 (irq_stat_reg[IRQ_ERR] & ctrl_reg[CTL_ERR_IRQ_EN]) |
                 (irq_stat_reg[IRQ_LOCK] & ctrl_reg[CTL_LOCK_IRQ_EN]);
  assign o_locked = (state_reg == LOCKED);

  // ************************************************************
  // read path
  // ************************************************************
  // unmapped addresses read as zero
  always_comb begin
    rdata_next = 16'h0000;
    case (i_req.addr)
      ADDR_TESTER_CONTROL: rdata_next = ctrl_reg;
      ADDR_BIT_COUNT_LOW: rdata_next = bit_snap_reg[15:0];
      // RL16 upper bit count half
      ADDR_BIT_COUNT_HIGH: rdata_next = bit_snap_reg[31:16];
      // RL14 flags and low byte
      ADDR_ERR_LOW_FLAGS: rdata_next = {err_snap_reg[7:0], 1'b0, flag_reg, o_locked};
      // RL15 upper error count
      ADDR_ERR_HIGH: rdata_next = err_snap_reg[23:8];
      ADDR_IRQ_STATUS: rdata_next = {13'h0000, irq_stat_reg};
      default: rdata_next = 16'h0000;
    endcase
  end

  // data stands only in the cycle after the strobe
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rdata_reg <= REG_RESET;
    end else begin
      rdata_reg <= i_req.rd ? rdata_next : 16'h0000;
    end
  end
  assign o_rdata = rdata_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);

  AST_BIT_COUNT_STEP: assert property ( // RL1
    i_rx.valid && !(&bit_count) |=> bit_count == $past(bit_count) + 32'h1)
    else $error("bit counter missed a bit");
  AST_ERR_COUNT_STEP: assert property ( // RL2
    mismatch && !(&err_count) |=> err_count == $past(err_count) + 24'h1)
    else $error("error counter missed an error");
  AST_COUNT_IN_HUNT: assert property ( // RL3
    state_reg == HUNT && i_rx.valid && !(&bit_count) |=> bit_count != $past(bit_count))
    else $error("bit counter stopped out of lock");
  AST_SNAPSHOT: assert property ( // RL4
    load_edge |=> bit_snap_reg == $past(bit_count) && err_snap_reg == $past(err_count))
    else $error("snapshot not taken");
  AST_SATURATE: assert property ( // RL5
    &bit_count |=> &bit_count)
    else $error("bit counter wrapped");
  AST_ERR_OVF_FLAG: assert property ( // RL6
    err_full_hit |=> flag_reg[ST_ERR_OVF] ##1 (flag_reg[ST_ERR_OVF] || $past(rd_flags)))
    else $error("error overflow flag not held");
  AST_BIT_OVF_CLEAR: assert property ( // RL7
    rd_flags && !bit_full_hit |=> !flag_reg[ST_BIT_OVF])
    else $error("bit overflow flag not cleared by read");
  AST_LOCK_GAIN: assert property ( // RL8
    state_reg == HUNT && match_reg == 6'd31 && i_rx.valid && !mismatch |=> o_locked)
    else $error("no lock after 32 matches");
  AST_LOCK_DROP: assert property ( // RL9
    $fell(o_locked) |-> $past(win_err_reg) == 3'd5 && $past(mismatch))
    else $error("lock dropped without six errors");
  AST_BIT_ERR_HUNT: assert property ( // RL10
    $rose(flag_reg[ST_BIT_ERR]) |-> $past(state_reg) == LOCKED)
    else $error("bit error flagged out of lock");
  AST_LOCK_LOST: assert property ( // RL11
    $fell(o_locked) |-> flag_reg[ST_LOCK_LOST])
    else $error("lock lost flag not set");
  AST_ZEROS_HOLD: assert property ( // RL12
    flag_reg[ST_ALL_ZEROS] && !zero_broken_reg && !zeros_broken |=> flag_reg[ST_ALL_ZEROS])
    else $error("all zeros cleared before a one");
  AST_ONES_SET: assert property ( // RL13
    ones_hit |=> flag_reg[ST_ALL_ONES])
    else $error("all ones not latched");
  AST_READ_LATENCY: assert property ( // RL14
    i_req.rd && i_req.addr == ADDR_ERR_LOW_FLAGS |=> o_rdata[15:8] == $past(err_snap_reg[7:0]))
    else $error("flag register layout wrong");
  AST_IRQ_MASK: assert property ( // RL18
    o_irq |-> |(irq_stat_reg & {ctrl_reg[CTL_LOCK_IRQ_EN], ctrl_reg[CTL_ERR_IRQ_EN], ctrl_reg[CTL_OVF_IRQ_EN]}))
    else $error("interrupt without enabled cause");

  COV_LOCK: cover property ($rose(o_locked));
  COV_DROP: cover property ($fell(o_locked));
  COV_SNAP: cover property (load_edge);
  COV_ZEROS: cover property (zeros_hit);
endmodule : rx_bit_error_tester
`default_nettype wire

// [verilog/sat_counter.sv]
`timescale 1ns/10ps
`default_nettype none
// saturating up-counter, pulses once when it reaches all ones
module sat_counter #(
  parameter int W = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rstn,
  // control
  input wire logic i_inc,
  // results
  output logic [W-1:0] o_count,
  output logic o_full_hit
);
  // ************************************************************
  // counter
  // ************************************************************
  // holds at all ones instead of wrapping
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_count <= '0;
    end else if (i_inc && !(&o_count)) begin
      o_count <= o_count + 1'b1;
    end
  end
  // pulse only on the step into saturation, so the flag is not re-set
  assign o_full_hit = i_inc && (o_count == {{(W-1){1'b1}}, 1'b0});
endmodule : sat_counter
`default_nettype wire
